/* common/led_sink_regs_pkg.sv */
// constants for the backlight and independent sink register slice
package led_sink_regs_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam int          CODE_W           = 7;
    localparam int          LAW_W            = 2;
    localparam int          OFFT_W           = 2;
    localparam int          NUM_SINKS        = 7;

    localparam logic [7:0]  OFFICE_DIM_ADDR  = 8'h0C;
    localparam logic [7:0]  DARK_MAX_ADDR    = 8'h0D;
    localparam logic [7:0]  DARK_DIM_ADDR    = 8'h0E;
    localparam logic [7:0]  SINK_LAW_ADDR    = 8'h0F;
    localparam logic [7:0]  SINK_EN_ADDR     = 8'h10;

    localparam logic [7:0]  CODE_MASK        = 8'h7F;
    localparam logic [7:0]  LAW_MASK         = 8'h03;
    localparam logic [7:0]  SINK_EN_MASK     = 8'h7F;
    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ    = 8'h00;
    localparam logic [6:0]  CODE_ZERO        = 7'h00;
    localparam logic [1:0]  OFF_TIME_NONE    = 2'h0;

    typedef enum logic [1:0] {
        LAW_LIN_LIN,
        LAW_SQR_LIN,
        LAW_SQR_CUBIC10,
        LAW_SQR_CUBIC11
    } fade_law_e;

    typedef enum logic [1:0] {
        LEVEL_DAYLIGHT,
        LEVEL_OFFICE,
        LEVEL_DARK,
        LEVEL_OTHER
    } ambient_level_e;
endpackage

/* rtl/sink_channel.sv */
// one independent sink: on/off level and synchronous sequence start
`timescale 1ns/100ps
module sink_channel
    import led_sink_regs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              clkEn,
    input  wire logic              enable,
    input  wire logic [OFFT_W-1:0] offTimeCode,
    output logic                   sinkOn,
    output logic                   blinkRun,
    output logic                   seqStart
);
    typedef struct packed {
        logic enPrev;
        logic on;
        logic blink;
        logic start;
    } state_s;

    state_s cur_r;
    state_s cur_nxt;

    always_comb begin
        cur_nxt        = cur_r;
        cur_nxt.enPrev = enable;
        // steady drive only when off time disabled; blinking left to timing engine
        cur_nxt.on     = enable && (offTimeCode == OFF_TIME_NONE);
        cur_nxt.blink  = enable && (offTimeCode != OFF_TIME_NONE);
        // rising enable starts the sequence, so one write aligns all the channels it turns on
        cur_nxt.start  = enable && !cur_r.enPrev;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_r <= '0;
        end else if (clkEn) begin
            cur_r <= cur_nxt;
        end
    end

    assign sinkOn   = cur_r.on;
    assign blinkRun = cur_r.blink;
    assign seqStart = cur_r.start;
endmodule

/* rtl/led_backlight_sink_regs.sv */
// register slice: backlight dim/max codes, sink fade law and sink enables
`timescale 1ns/100ps
module led_backlight_sink_regs
    import led_sink_regs_pkg::*;
#(
    parameter int SINKS = NUM_SINKS
) (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    clkEn,
    input  wire logic [ADDR_W-1:0]       regAddr,
    input  wire logic [DATA_W-1:0]       regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    input  wire logic [1:0]              ambientLevel,
    input  wire logic                    dimTimeout,
    input  wire logic                    dimRequest,
    input  wire logic [CODE_W-1:0]       otherLevelCode,
    input  wire logic [SINKS*OFFT_W-1:0] sinkOffTime,
    output logic [DATA_W-1:0]            regRdData,
    output logic                         regRdValid,
    output logic [CODE_W-1:0]            backlightCode,
    output logic                         backlightDim,
    output logic [LAW_W-1:0]             sinkFadeLawSel,
    output logic                         sinkSquareDac,
    output logic                         sinkNonlinearTime,
    output logic [SINKS-1:0]             sinkEnable,
    output logic [SINKS-1:0]             sinkOn,
    output logic [SINKS-1:0]             sinkBlinkRun,
    output logic [SINKS-1:0]             sinkSeqStart
);
    typedef struct packed {
        logic [CODE_W-1:0] officeDimCode;
        logic [CODE_W-1:0] darkMaxCode;
        logic [CODE_W-1:0] darkDimCode;
        logic [LAW_W-1:0]  fadeLaw;
        logic [SINKS-1:0]  enables;
        logic [DATA_W-1:0] rdData;
        logic              rdValid;
        logic [CODE_W-1:0] blCode;
        logic              blDim;
        logic              squareDac;
        logic              nonlinTime;
    } state_s;

    state_s cur_r;
    state_s cur_nxt;
    logic   dimNow;

    always_comb begin
        cur_nxt         = cur_r;
        dimNow          = dimTimeout || dimRequest;
        cur_nxt.rdValid = regRd;

        // write path: only defined bits stored, reserved bits dropped
        if (regWr) begin
            unique case (regAddr)
                OFFICE_DIM_ADDR: cur_nxt.officeDimCode = regWrData[CODE_W-1:0];
                DARK_MAX_ADDR:   cur_nxt.darkMaxCode   = regWrData[CODE_W-1:0];
                DARK_DIM_ADDR:   cur_nxt.darkDimCode   = regWrData[CODE_W-1:0];
                SINK_LAW_ADDR:   cur_nxt.fadeLaw       = regWrData[LAW_W-1:0];
                SINK_EN_ADDR:    cur_nxt.enables       = regWrData[SINKS-1:0];
                default: ;
            endcase
        end

        // read path: registered data, reserved bits read zero
        if (regRd) begin
            unique case (regAddr)
                OFFICE_DIM_ADDR: cur_nxt.rdData = DATA_W'(cur_r.officeDimCode) & CODE_MASK;
                DARK_MAX_ADDR:   cur_nxt.rdData = DATA_W'(cur_r.darkMaxCode) & CODE_MASK;
                DARK_DIM_ADDR:   cur_nxt.rdData = DATA_W'(cur_r.darkDimCode) & CODE_MASK;
                SINK_LAW_ADDR:   cur_nxt.rdData = DATA_W'(cur_r.fadeLaw) & LAW_MASK;
                SINK_EN_ADDR:    cur_nxt.rdData = DATA_W'(cur_r.enables) & SINK_EN_MASK;
                default:         cur_nxt.rdData = UNMAPPED_READ;
            endcase
        end

        // backlight code: dim code of the office or dark level while dim is asked for
        unique case (ambientLevel)
            LEVEL_OFFICE: begin
                cur_nxt.blCode = dimNow ? cur_r.officeDimCode : otherLevelCode;
            end
            LEVEL_DARK: begin
                cur_nxt.blCode = dimNow ? cur_r.darkDimCode : cur_r.darkMaxCode;
            end
            default: begin
                // daylight and other levels are held in registers outside this slice
                cur_nxt.blCode = otherLevelCode;
            end
        endcase
        cur_nxt.blDim = dimNow;

        // code passes straight to the DAC so 00 is zero and 7F full scale
        unique case (fade_law_e'(cur_r.fadeLaw))
            LAW_LIN_LIN: begin
                cur_nxt.squareDac  = 1'b0;
                cur_nxt.nonlinTime = 1'b0;
            end
            LAW_SQR_LIN: begin
                cur_nxt.squareDac  = 1'b1;
                cur_nxt.nonlinTime = 1'b0;
            end
            LAW_SQR_CUBIC10, LAW_SQR_CUBIC11: begin
                // profile picked by the fade engine from sinkFadeLawSel
                cur_nxt.squareDac  = 1'b1;
                cur_nxt.nonlinTime = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_r <= '0;
        end else if (clkEn) begin
            cur_r <= cur_nxt;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < SINKS; ch++) begin : g_sink
            sink_channel u_sink (
                .clk         (clk),
                .rst_b       (rst_b),
                .clkEn       (clkEn),
                .enable      (cur_r.enables[ch]),
                .offTimeCode (sinkOffTime[ch*OFFT_W +: OFFT_W]),
                .sinkOn      (sinkOn[ch]),
                .blinkRun    (sinkBlinkRun[ch]),
                .seqStart    (sinkSeqStart[ch])
            );
        end
    endgenerate

    assign regRdData         = cur_r.rdData;
    assign regRdValid        = cur_r.rdValid;
    assign backlightCode     = cur_r.blCode;
    assign backlightDim      = cur_r.blDim;
    assign sinkFadeLawSel    = cur_r.fadeLaw;
    assign sinkSquareDac     = cur_r.squareDac;
    assign sinkNonlinearTime = cur_r.nonlinTime;
    assign sinkEnable        = cur_r.enables;
endmodule

/* dv/led_backlight_sink_regs_monitor.sv */
// assertions on the sink register slice ports
`timescale 1ns/100ps
module led_backlight_sink_regs_monitor
    import led_sink_regs_pkg::*;
#(parameter int SINKS = NUM_SINKS) (
    input wire logic                    clk,
    input wire logic                    rst_b,
    input wire logic                    clkEn,
    input wire logic [ADDR_W-1:0]       regAddr,
    input wire logic [DATA_W-1:0]       regWrData,
    input wire logic                    regWr,
    input wire logic                    regRd,
    input wire logic [SINKS*OFFT_W-1:0] sinkOffTime,
    input wire logic [DATA_W-1:0]       regRdData,
    input wire logic                    regRdValid,
    input wire logic [LAW_W-1:0]        sinkFadeLawSel,
    input wire logic                    sinkSquareDac,
    input wire logic                    sinkNonlinearTime,
    input wire logic [SINKS-1:0]        sinkEnable,
    input wire logic [SINKS-1:0]        sinkOn
);
    logic [SINKS-1:0] offNone;
    // off time 00 is steady on; other codes hand over to blinking
    always_comb for (int i = 0; i < SINKS; i++) offNone[i] = sinkOffTime[2*i+:2] == OFF_TIME_NONE;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_rd_valid: assert property (clkEn && regRd |=> regRdValid) else $error("read valid missing");
    a_rd_stray: assert property (clkEn && !regRd |=> !regRdValid) else $error("stray read valid");
    a_law_rsvd: assert property (clkEn && regRd && regAddr == SINK_LAW_ADDR
        |=> regRdData[7:2] == 6'h00) else $error("law reserved bits set");
    a_en_write: assert property (clkEn && regWr && regAddr == SINK_EN_ADDR
        |=> sinkEnable == $past(regWrData[6:0])) else $error("enable write lost");
    a_en_hold: assert property (!(regWr && regAddr == SINK_EN_ADDR)
        |=> $stable(sinkEnable)) else $error("enable changed unasked");
    a_law_write: assert property (clkEn && regWr && regAddr == SINK_LAW_ADDR
        |=> sinkFadeLawSel == $past(regWrData[1:0])) else $error("law write lost");
    a_law_decode: assert property (sinkFadeLawSel == $past(sinkFadeLawSel, 2) && $stable(sinkFadeLawSel)
        |-> sinkSquareDac == (sinkFadeLawSel != 2'h0) && sinkNonlinearTime == sinkFadeLawSel[1])
        else $error("law decode wrong");
    a_sink_steady: assert property (clkEn |=> sinkOn == $past(sinkEnable & offNone)) else $error("sink on wrong");
    c_read: cover property (regRdValid);
    c_all_on: cover property (&sinkEnable);
    c_cubic: cover property (sinkNonlinearTime);
endmodule
bind led_backlight_sink_regs led_backlight_sink_regs_monitor #(.SINKS(SINKS)) monitor_i (.*);

/* dv/reg_host_model.sv */
// host model on the slice's register write and read port
`timescale 1ns/100ps
module reg_host_model
    import led_sink_regs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] regRdData,
    input  wire logic              regRdValid,
    output logic [ADDR_W-1:0]      regAddr,
    output logic [DATA_W-1:0]      regWrData,
    output logic                   regWr,
    output logic                   regRd
);
    initial {regAddr, regWrData, regWr, regRd} = 18'h0;
    // released lines show the inverse so a stale value never passes
    task automatic xfer(input logic [7:0] a, d, input logic w, output logic [7:0] q, output logic ok);
        @(posedge clk);
        #2;
        regAddr = a;
        regWrData = d;
        regWr = w;
        regRd = !w;
        @(posedge clk);
        #2;
        q = regRdData;
        ok = regRdValid === !w;
        {regWr, regRd} = 2'h0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
endmodule

/* dv/led_backlight_sink_regs_bench.sv */
// self-checking bench for the sink register slice
`timescale 1ns/100ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin errTotal++; \
    $display("wrong value at %0t got %h expected %h", $time, g, e); end end
module led_backlight_sink_regs_bench
    import led_sink_regs_pkg::*;
;
    logic        clk, rst_b, clkEn, regWr, regRd, dimTimeout, dimRequest, regRdValid, backlightDim;
    logic        sinkSquareDac, sinkNonlinearTime, ok;
    logic [7:0]  regAddr, regWrData, regRdData, q, adr [5], msk [5];
    logic [6:0]  otherLevelCode, backlightCode, sinkEnable, sinkOn, sinkBlinkRun, sinkSeqStart, ex [5];
    logic [1:0]  ambientLevel, sinkFadeLawSel, lvl [5], dm [5];
    logic [13:0] sinkOffTime;
    int          errTotal, totalChecks;
    led_backlight_sink_regs led_backlight_sink_regs_i (.*);
    reg_host_model reg_host_model_i (.*);
    always #20 clk = ~clk;
    task automatic acc(input logic [7:0] a, d, input logic w, input logic [7:0] e);
        reg_host_model_i.xfer(a, d, w, q, ok);
        `CHK(ok, 1'b1)
        if (!w) `CHK(q, e)
    endtask
    task automatic printVerdict;
        $display("checks %0d errors %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {clk, rst_b, clkEn, dimTimeout, dimRequest, ambientLevel} = 7'h10;
        otherLevelCode = 7'h5A;
        sinkOffTime = 14'h1000;
        adr = '{OFFICE_DIM_ADDR, DARK_MAX_ADDR, DARK_DIM_ADDR, SINK_LAW_ADDR, SINK_EN_ADDR};
        msk = '{CODE_MASK, CODE_MASK, CODE_MASK, LAW_MASK, SINK_EN_MASK};
        lvl = '{LEVEL_OFFICE, LEVEL_DARK, LEVEL_DARK, LEVEL_DAYLIGHT, LEVEL_OFFICE};
        dm = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h0};
        ex = '{7'h15, 7'h2A, 7'h33, 7'h5A, 7'h5A};
        repeat (2) @(posedge clk);
        #2;
        rst_b = 1'b1;
        for (int i = 0; i < 5; i++) acc(adr[i], 8'h00, 1'b0, REG_RESET);
        acc(8'h11, 8'h00, 1'b0, UNMAPPED_READ);
        for (int i = 0; i < 5; i++) begin
            acc(adr[i], 8'hFF, 1'b1, 8'h00);
            acc(adr[i], 8'h00, 1'b0, msk[i]);
        end
        for (int l = 0; l < 4; l++) begin
            acc(SINK_LAW_ADDR, 8'(l), 1'b1, 8'h00);
            repeat (2) @(posedge clk);
            #2;
            `CHK(sinkSquareDac, l != 0)
            `CHK(sinkNonlinearTime, l > 1)
        end
        acc(SINK_EN_ADDR, 8'h00, 1'b1, 8'h00);
        acc(SINK_EN_ADDR, 8'h01, 1'b1, 8'h00);
        @(posedge clk);
        #2;
        `CHK({sinkEnable, sinkOn}, 14'h0081)
        acc(SINK_EN_ADDR, 8'hFF, 1'b1, 8'h00);
        @(posedge clk);
        #2;
        `CHK({sinkOn, sinkBlinkRun, sinkSeqStart}, 21'h0FE07E)
        acc(SINK_EN_ADDR, 8'h00, 1'b1, 8'h00);
        @(posedge clk);
        #2;
        `CHK(sinkOn, 7'h00)
        // write with clock enable low must not land
        clkEn = 1'b0;
        acc(OFFICE_DIM_ADDR, 8'h00, 1'b1, 8'h00);
        clkEn = 1'b1;
        acc(OFFICE_DIM_ADDR, 8'h00, 1'b0, CODE_MASK);
        acc(OFFICE_DIM_ADDR, 8'h95, 1'b1, 8'h00);
        acc(DARK_MAX_ADDR, 8'h33, 1'b1, 8'h00);
        acc(DARK_DIM_ADDR, 8'h2A, 1'b1, 8'h00);
        for (int i = 0; i < 5; i++) begin
            ambientLevel = lvl[i];
            {dimTimeout, dimRequest} = dm[i];
            repeat (3) @(posedge clk);
            #2;
            `CHK(backlightCode, ex[i])
            `CHK(backlightDim, dm[i] != 2'h0)
        end
        printVerdict();
    end
endmodule
